// >>> src/slp_ctrl.sv
// sleep and wake-up sequencer with apb registers and interrupt
// assumes i_core_clk is the always-on oscillator; core clock gated outside
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "slp_defs.svh"

// Notes on behaviour
// - only sleep instruction enters low power
// - sleep entry clears watchdog, sets timeout flag, clears power-down flag, stops oscillator
// - io pins hold pre-sleep drive state
// - watchdog reset never drives master clear pin
// - wake on clear, watchdog, or enabled irq
// - master clear resets; others continue execution
// - power-down set at power-up; watchdog wake clears timeout
// - prefetch address is pc plus one
// - irq wake needs own enable, ignores gie
// - after irq wake, vector only if gie
// - pending enabled flag wakes right after sleep
// - every wake-up clears the watchdog count
// - crystal modes wait 1024 periods, rc none
// - source flags set regardless of enables
module slp_ctrl #(
    parameter int P_WDT_TIMEOUT_CYCLES = `SLP_WDT_CYCLES
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // core instruction flow
    input wire logic i_sleep_exec,
    input wire logic i_clrwdt_exec,
    input wire logic [`SLP_PC_W-1:0] i_pc,
    output logic [`SLP_PC_W-1:0] o_prefetch_addr,
    output logic o_core_clk_en,
    output logic o_osc_drv_en,
    output logic o_resume,
    output logic o_vector_req,
    // resets
    input wire logic i_master_clear_pin_n,
    output logic o_master_clear_pin_oe,
    output logic o_dev_reset,
    output logic o_wdt_reset,
    // interrupt sources
    input wire logic i_external_edge_irq_pin,
    input wire logic i_port_change,
    input wire logic i_cmp_change,
    // io drive hold
    input wire logic [`SLP_IO_W-1:0] i_io_out,
    input wire logic [`SLP_IO_W-1:0] i_io_oe,
    output logic [`SLP_IO_W-1:0] o_io_out,
    output logic [`SLP_IO_W-1:0] o_io_oe,
    // status flags and interrupt
    output logic o_timeout_flag,
    output logic o_power_down_flag,
    output logic o_irq
);

    // registers
    slp_pkg::slp_state_t state_reg;
    slp_pkg::slp_state_t state_next;
    logic [`SLP_CTRL_W-1:0] ctrl_reg;
    logic [`SLP_SRC_W-1:0] src_flags_reg;
    logic [`SLP_EVT_W-1:0] evt_reg;
    logic [`SLP_EVT_W-1:0] evt_mask_reg;
    logic timeout_flag_reg;
    logic power_down_flag_reg;
    logic ext_pin_reg;
    logic wake_master_clear_pin_reg;
    logic wake_irq_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [`SLP_PC_W-1:0] prefetch_reg;
    logic core_clk_en_reg;
    logic osc_drv_en_reg;
    logic resume_reg;
    logic vector_reg;
    logic dev_reset_reg;
    logic wdt_reset_reg;
    logic master_clear_pin_oe_reg;
    logic [`SLP_IO_W-1:0] io_out_reg;
    logic [`SLP_IO_W-1:0] io_oe_reg;
    logic irq_reg;

    // sub-block wires
    logic [`SLP_WDT_W-1:0] wdt_count;
    logic wdt_timeout;
    logic ost_busy;
    logic ost_done;

    // apb decode
    wire apb_setup = i_psel & ~i_penable;
    wire apb_wr = i_psel & i_penable & pready_reg & i_pwrite;
    wire hit_ctrl = (i_paddr == `SLP_OFS_CTRL);
    wire hit_status = (i_paddr == `SLP_OFS_STATUS);
    wire hit_src = (i_paddr == `SLP_OFS_SRC_FLAGS);
    wire hit_evt = (i_paddr == `SLP_OFS_EVT);
    wire hit_mask = (i_paddr == `SLP_OFS_EVT_MASK);
    wire hit_wdt = (i_paddr == `SLP_OFS_WDT_COUNT);
    wire hit_any = hit_ctrl | hit_status | hit_src | hit_evt | hit_mask |
                   hit_wdt;
    wire [31:0] status_word = {28'h0000000, ost_busy,
                               state_reg == slp_pkg::SLP_ST_SLEEP,
                               power_down_flag_reg, timeout_flag_reg};
    logic [31:0] rd_word;
    always_comb begin
        if (hit_ctrl) begin
            rd_word = {24'h000000, ctrl_reg};
        end else if (hit_status) begin
            rd_word = status_word;
        end else if (hit_src) begin
            rd_word = {29'h00000000, src_flags_reg};
        end else if (hit_evt) begin
            rd_word = {29'h00000000, evt_reg};
        end else if (hit_mask) begin
            rd_word = {29'h00000000, evt_mask_reg};
        end else if (hit_wdt) begin
            rd_word = {10'h000, wdt_count};
        end else begin
            rd_word = 32'h00000000;
        end
    end

    // control fields
    wire wdt_en = ctrl_reg[`SLP_CTRL_WDT_EN];
    wire global_irq_enable = ctrl_reg[`SLP_CTRL_GIE];
    wire ext_rise = ctrl_reg[`SLP_CTRL_EXT_RISE];
    wire is_rc = ctrl_reg[`SLP_CTRL_OSC_HI:`SLP_CTRL_OSC_LO] ==
                 slp_pkg::SLP_OSC_RC;
    wire [`SLP_SRC_W-1:0] src_en = {ctrl_reg[`SLP_CTRL_CMP_EN],
                                    ctrl_reg[`SLP_CTRL_PORT_EN],
                                    ctrl_reg[`SLP_CTRL_EXT_EN]};

    // interrupt source flags
    wire ext_edge = ext_rise ? (i_external_edge_irq_pin & ~ext_pin_reg) :
                               (~i_external_edge_irq_pin & ext_pin_reg);
    wire [`SLP_SRC_W-1:0] src_set = {i_cmp_change, i_port_change, ext_edge};
    wire [`SLP_SRC_W-1:0] src_clr =
        (apb_wr & hit_src) ? i_pwdata[`SLP_SRC_W-1:0] : '0;
    wire [`SLP_SRC_W-1:0] src_flags_next =
        (src_flags_reg & ~src_clr) | src_set;
    wire irq_pending = |(src_flags_reg & src_en);

    // sequencer conditions
    wire asleep = state_reg == slp_pkg::SLP_ST_SLEEP;
    wire master_clear_pin_low = ~i_master_clear_pin_n;
    wire sleep_enter = (state_reg == slp_pkg::SLP_ST_RUN) &
                       i_sleep_exec & ~master_clear_pin_low;
    wire wdt_wake = asleep & wdt_en & wdt_timeout;
    wire irq_wake = asleep & irq_pending;
    wire wake = asleep & (master_clear_pin_low | wdt_wake | irq_wake);
    wire wdt_clear = i_clrwdt_exec | sleep_enter | wake;
    wire ost_start = wake & ~is_rc;

    // state machine
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            slp_pkg::SLP_ST_RUN: begin
                if (sleep_enter) begin
                    state_next = slp_pkg::SLP_ST_SLEEP;
                end
            end
            slp_pkg::SLP_ST_SLEEP: begin
                if (wake && is_rc) begin
                    state_next = slp_pkg::SLP_ST_RESUME;
                end else if (wake) begin
                    state_next = slp_pkg::SLP_ST_OST;
                end
            end
            slp_pkg::SLP_ST_OST: begin
                if (ost_done) begin
                    state_next = slp_pkg::SLP_ST_RESUME;
                end
            end
            slp_pkg::SLP_ST_RESUME: begin
                state_next = slp_pkg::SLP_ST_RUN;
            end
            default: begin
                state_next = slp_pkg::SLP_ST_RUN;
            end
        endcase
    end

    // status flags
    wire timeout_flag_next =
        (wdt_en & wdt_timeout) ? 1'b0 :
        (sleep_enter | i_clrwdt_exec) ? 1'b1 : timeout_flag_reg;
    wire power_down_flag_next =
        sleep_enter ? 1'b0 :
        i_clrwdt_exec ? 1'b1 : power_down_flag_reg;

    // event status
    wire [`SLP_EVT_W-1:0] evt_set = {wdt_en & wdt_timeout, wake, sleep_enter};
    wire [`SLP_EVT_W-1:0] evt_clr =
        (apb_wr & hit_evt) ? i_pwdata[`SLP_EVT_W-1:0] : '0;
    wire [`SLP_EVT_W-1:0] evt_next = (evt_reg & ~evt_clr) | evt_set;

    // output next values
    wire resume_start = state_reg == slp_pkg::SLP_ST_RESUME;
    wire resume_next = resume_start & ~wake_master_clear_pin_reg;
    wire vector_next = resume_next & wake_irq_reg & global_irq_enable;
    wire clk_en_next = (state_next == slp_pkg::SLP_ST_RUN) |
                       (state_next == slp_pkg::SLP_ST_RESUME);
    wire osc_next = state_next != slp_pkg::SLP_ST_SLEEP;
    wire wdt_reset_next = ~asleep & wdt_en & wdt_timeout;
    wire hold_io = state_reg != slp_pkg::SLP_ST_RUN;

    // apb slave
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg <= apb_setup ? rd_word : prdata_reg;
            pready_reg <= apb_setup;
            pslverr_reg <= apb_setup & ~hit_any;
        end
    end

    // software registers
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_reg <= `SLP_CTRL_RST;
            evt_mask_reg <= '0;
            evt_reg <= '0;
            src_flags_reg <= '0;
            ext_pin_reg <= 1'b0;
        end else begin
            if (apb_wr && hit_ctrl) begin
                ctrl_reg <= i_pwdata[`SLP_CTRL_W-1:0];
            end
            if (apb_wr && hit_mask) begin
                evt_mask_reg <= i_pwdata[`SLP_EVT_W-1:0];
            end
            evt_reg <= evt_next;
            src_flags_reg <= src_flags_next;
            ext_pin_reg <= i_external_edge_irq_pin;
        end
    end

    // sequencer and flags, on the always-on clock
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= slp_pkg::SLP_ST_RUN;
            timeout_flag_reg <= 1'b1;
            power_down_flag_reg <= 1'b1;
            wake_master_clear_pin_reg <= 1'b0;
            wake_irq_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            timeout_flag_reg <= timeout_flag_next;
            power_down_flag_reg <= power_down_flag_next;
            if (wake) begin
                wake_master_clear_pin_reg <= master_clear_pin_low;
                wake_irq_reg <= irq_wake & ~master_clear_pin_low & ~wdt_wake;
            end
        end
    end

    // core-facing outputs
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            prefetch_reg <= '0;
            core_clk_en_reg <= 1'b1;
            osc_drv_en_reg <= 1'b1;
            resume_reg <= 1'b0;
            vector_reg <= 1'b0;
            dev_reset_reg <= 1'b0;
            wdt_reset_reg <= 1'b0;
            master_clear_pin_oe_reg <= 1'b0;
        end else begin
            if (sleep_enter) begin
                prefetch_reg <= i_pc + 1'b1;
            end
            core_clk_en_reg <= clk_en_next;
            osc_drv_en_reg <= osc_next;
            resume_reg <= resume_next;
            vector_reg <= vector_next;
            dev_reset_reg <= master_clear_pin_low;
            wdt_reset_reg <= wdt_reset_next;
            master_clear_pin_oe_reg <= 1'b0;
        end
    end

    // io hold and interrupt output
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            io_out_reg <= '0;
            io_oe_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            if (!hold_io) begin
                io_out_reg <= i_io_out;
                io_oe_reg <= i_io_oe;
            end
            irq_reg <= |(evt_next & evt_mask_reg);
        end
    end

    // watchdog
    slp_wdt #(
        .P_TIMEOUT_CYCLES(P_WDT_TIMEOUT_CYCLES)
    ) u_wdt (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_enable(wdt_en),
        .i_clear(wdt_clear),
        .o_count(wdt_count),
        .o_timeout(wdt_timeout)
    );

    // oscillator start-up delay
    slp_ost u_ost (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_start(ost_start),
        .o_busy(ost_busy),
        .o_done(ost_done)
    );

    assign o_prdata = prdata_reg;
    assign o_pready = pready_reg;
    assign o_pslverr = pslverr_reg;
    assign o_prefetch_addr = prefetch_reg;
    assign o_core_clk_en = core_clk_en_reg;
    assign o_osc_drv_en = osc_drv_en_reg;
    assign o_resume = resume_reg;
    assign o_vector_req = vector_reg;
    assign o_master_clear_pin_oe = master_clear_pin_oe_reg;
    assign o_dev_reset = dev_reset_reg;
    assign o_wdt_reset = wdt_reset_reg;
    assign o_io_out = io_out_reg;
    assign o_io_oe = io_oe_reg;
    assign o_timeout_flag = timeout_flag_reg;
    assign o_power_down_flag = power_down_flag_reg;
    assign o_irq = irq_reg;

endmodule : slp_ctrl

// >>> src/slp_defs.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by every sleep/wake-up control source file except the package, which defines its own encodings
`ifndef SLP_DEFS_SVH
`define SLP_DEFS_SVH

// register byte offsets
`define SLP_OFS_CTRL 8'h00
`define SLP_OFS_STATUS 8'h04
`define SLP_OFS_SRC_FLAGS 8'h08
`define SLP_OFS_EVT 8'h0C
`define SLP_OFS_EVT_MASK 8'h10
`define SLP_OFS_WDT_COUNT 8'h14

// control register fields
`define SLP_CTRL_WDT_EN 0
`define SLP_CTRL_OSC_LO 1
`define SLP_CTRL_OSC_HI 2
`define SLP_CTRL_GIE 3
`define SLP_CTRL_EXT_EN 4
`define SLP_CTRL_PORT_EN 5
`define SLP_CTRL_CMP_EN 6
`define SLP_CTRL_EXT_RISE 7
`define SLP_CTRL_W 8
`define SLP_CTRL_RST 8'h81

// status register fields
`define SLP_STAT_TIMEOUT 0
`define SLP_STAT_PWRDN 1
`define SLP_STAT_ASLEEP 2
`define SLP_STAT_OST 3

// interrupt source flags: ext edge, port change, comparator
`define SLP_SRC_W 3
`define SLP_SRC_EXT 0
`define SLP_SRC_PORT 1
`define SLP_SRC_CMP 2

// event status: sleep entered, woken, watchdog time-out
`define SLP_EVT_W 3
`define SLP_EVT_SLEEP 0
`define SLP_EVT_WAKE 1
`define SLP_EVT_WDT 2

// widths
`define SLP_IO_W 13
`define SLP_PC_W 11
`define SLP_WDT_W 22

// timing
`define SLP_CLK_PERIOD_NS 8
`define SLP_WDT_TIMEOUT_US 18000
`define SLP_WDT_CYCLES ((`SLP_WDT_TIMEOUT_US * 1000) / `SLP_CLK_PERIOD_NS)
`define SLP_OST_TOSC 1024
`define SLP_OST_CYCLES (`SLP_OST_TOSC * 1)
`define SLP_OST_W 11

`endif

// >>> src/slp_pkg.sv
// types shared by the sleep/wake-up control block
// defines its own encodings; takes no constants from slp_defs.svh
package slp_pkg;

    // sequencer states, one-hot
    typedef enum logic [3:0] {
        SLP_ST_RUN = 4'b0001,
        SLP_ST_SLEEP = 4'b0010,
        SLP_ST_OST = 4'b0100,
        SLP_ST_RESUME = 4'b1000
    } slp_state_t;

    // oscillator modes
    typedef enum logic [1:0] {
        SLP_OSC_LP = 2'h0,
        SLP_OSC_XT = 2'h1,
        SLP_OSC_HS = 2'h2,
        SLP_OSC_RC = 2'h3
    } slp_osc_mode_t;

endpackage : slp_pkg

// >>> src/slp_wdt.sv
// watchdog counter running on the always-on oscillator clock
// assumes the clock keeps running while the core clock is gated
`timescale 1ns/100ps
`include "slp_defs.svh"

module slp_wdt #(
    parameter int P_TIMEOUT_CYCLES = `SLP_WDT_CYCLES
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // control
    input wire logic i_enable,
    input wire logic i_clear,
    // status
    output logic [`SLP_WDT_W-1:0] o_count,
    output logic o_timeout
);

    localparam logic [`SLP_WDT_W-1:0] LAST =
        `SLP_WDT_W'(P_TIMEOUT_CYCLES - 1);

    logic [`SLP_WDT_W-1:0] count_reg;
    logic timeout_reg;
    wire at_last = i_enable & ~i_clear & (count_reg == LAST);
    wire [`SLP_WDT_W-1:0] count_next =
        (i_clear | ~i_enable | at_last) ? '0 : count_reg + 1'b1;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            count_reg <= '0;
            timeout_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            timeout_reg <= at_last;
        end
    end

    assign o_count = count_reg;
    assign o_timeout = timeout_reg;

endmodule : slp_wdt

// >>> src/slp_ost.sv
// oscillator start-up delay counter
// assumes one clock cycle per oscillator period
`timescale 1ns/100ps
`include "slp_defs.svh"

module slp_ost (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // control
    input wire logic i_start,
    // status
    output logic o_busy,
    output logic o_done
);

    localparam logic [`SLP_OST_W-1:0] LAST =
        `SLP_OST_W'(`SLP_OST_CYCLES - 1);

    logic [`SLP_OST_W-1:0] count_reg;
    logic busy_reg;
    logic done_reg;
    wire finish = busy_reg & (count_reg == LAST);

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            count_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            count_reg <= (i_start | finish) ? '0 :
                         busy_reg ? count_reg + 1'b1 : count_reg;
            busy_reg <= i_start | (busy_reg & ~finish);
            done_reg <= finish;
        end
    end

    assign o_busy = busy_reg;
    assign o_done = done_reg;

endmodule : slp_ost

// >>> sim/slp_ctrl_monitor.sv
// assertion checker for the sleep and wake-up sequencer ports
// assumes it is bound onto slp_ctrl and sees its ports only
`timescale 1ns/100ps
`include "slp_defs.svh"

module slp_ctrl_monitor (
    // clock, reset and watched inputs
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_sleep_exec,
    input wire logic [`SLP_PC_W-1:0] i_pc,
    input wire logic i_master_clear_pin_n,
    // watched outputs
    input wire logic [`SLP_PC_W-1:0] o_prefetch_addr,
    input wire logic o_core_clk_en,
    input wire logic o_osc_drv_en,
    input wire logic o_resume,
    input wire logic o_vector_req,
    input wire logic o_master_clear_pin_oe,
    input wire logic o_dev_reset,
    input wire logic [`SLP_IO_W-1:0] o_io_out,
    input wire logic o_timeout_flag,
    input wire logic o_power_down_flag
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    // sleep accepted while running
    logic take_sleep;
    assign take_sleep = i_sleep_exec & o_core_clk_en & i_master_clear_pin_n;

    a_sleep_entry_flags: assert property (take_sleep |=> !o_core_clk_en &&
        !o_osc_drv_en && !o_power_down_flag && o_timeout_flag)
        else $error("sleep entry outputs wrong");
    a_prefetch_next_pc: assert property (take_sleep |=>
        o_prefetch_addr == `SLP_PC_W'($past(i_pc) + 1'b1))
        else $error("prefetch address not pc plus one");
    a_gate_only_sleep: assert property ($fell(o_core_clk_en) |->
        $past(i_sleep_exec)) else $error("clock gated without sleep");
    a_pd_only_sleep: assert property ($fell(o_power_down_flag) |->
        $past(i_sleep_exec)) else $error("power-down cleared without sleep");
    a_pin_never_driven: assert property (!o_master_clear_pin_oe)
        else $error("master clear pin driven");
    a_io_held_asleep: assert property (!o_core_clk_en &&
        !$past(o_core_clk_en) |-> $stable(o_io_out))
        else $error("io changed while asleep");
    a_clear_resets: assert property (!i_master_clear_pin_n |=>
        o_dev_reset) else $error("master clear did not reset");
    a_no_resume_clear: assert property (o_dev_reset |-> !o_resume)
        else $error("resume during master clear");
    a_resume_clocked: assert property (o_resume |->
        o_core_clk_en && o_osc_drv_en) else $error("resume with clock off");
    a_vector_with_resume: assert property (o_vector_req |-> o_resume)
        else $error("vector without resume");

    c_sleep: cover property (take_sleep);
    c_resume: cover property (o_resume);
    c_vector: cover property (o_vector_req);
    c_clear: cover property (o_dev_reset);
endmodule : slp_ctrl_monitor

bind slp_ctrl slp_ctrl_monitor u_mon (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_sleep_exec(i_sleep_exec),
    .i_pc(i_pc),
    .i_master_clear_pin_n(i_master_clear_pin_n),
    .o_prefetch_addr(o_prefetch_addr),
    .o_core_clk_en(o_core_clk_en),
    .o_osc_drv_en(o_osc_drv_en),
    .o_resume(o_resume),
    .o_vector_req(o_vector_req),
    .o_master_clear_pin_oe(o_master_clear_pin_oe),
    .o_dev_reset(o_dev_reset),
    .o_io_out(o_io_out),
    .o_timeout_flag(o_timeout_flag),
    .o_power_down_flag(o_power_down_flag)
);

// >>> sim/slp_core_model.sv
// core and interrupt source model driving the sequencer
// assumes the bench calls its tasks; all changes follow a rising edge
`timescale 1ns/100ps
`include "slp_defs.svh"

module slp_core_model (
    // clock
    input wire logic i_core_clk,
    // instruction flow and sources
    output logic o_sleep_exec,
    output logic o_clrwdt_exec,
    output logic [`SLP_PC_W-1:0] o_pc,
    output logic o_ext_pin,
    output logic o_port_change,
    output logic o_cmp_change,
    // pin drive
    output logic [`SLP_IO_W-1:0] o_io_out,
    output logic [`SLP_IO_W-1:0] o_io_oe
);
    initial begin
        o_sleep_exec = 1'b0;
        o_clrwdt_exec = 1'b0;
        o_pc = 11'h000;
        o_ext_pin = 1'b0;
        o_port_change = 1'b0;
        o_cmp_change = 1'b0;
        o_io_out = 13'h0A5A;
        o_io_oe = 13'h1FFF;
    end

    // word after each sleep is a no-op, so wake runs nothing unwanted
    task sleep_at(input logic [`SLP_PC_W-1:0] pc);
        @(posedge i_core_clk);
        o_sleep_exec <= 1'b1;
        o_pc <= pc;
        @(posedge i_core_clk);
        o_sleep_exec <= 1'b0;
        o_pc <= ~pc;
    endtask : sleep_at

    // one-cycle source event: 0 port change, 1 comparator
    task pulse(input logic which);
        @(posedge i_core_clk);
        o_port_change <= ~which;
        o_cmp_change <= which;
        @(posedge i_core_clk);
        o_port_change <= 1'b0;
        o_cmp_change <= 1'b0;
    endtask : pulse

    // edge pin level and pin drive, changed after an edge
    task pins(input logic ext, input logic [`SLP_IO_W-1:0] out,
              input logic [`SLP_IO_W-1:0] oe);
        @(posedge i_core_clk);
        o_ext_pin <= ext;
        o_io_out <= out;
        o_io_oe <= oe;
    endtask : pins

    // one-cycle clear-watchdog instruction
    task clear_watchdog;
        @(posedge i_core_clk);
        o_clrwdt_exec <= 1'b1;
        @(posedge i_core_clk);
        o_clrwdt_exec <= 1'b0;
    endtask : clear_watchdog
endmodule : slp_core_model

// >>> sim/sleep_wakeup_control_tb_top.sv
// self-checking bench for the sleep and wake-up sequencer
// assumes slp_ctrl, the core model and the bound checker
`timescale 1ns/100ps
`include "slp_defs.svh"

module sleep_wakeup_control_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic master_clear_pin_n = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, perr, sleep_x, clrwdt, ext_pin, port_c, cmp_c;
    logic clk_en, osc_en, resume, vec, dev_rst, wdt_rst, to_f, pd_f, irq;
    logic master_clear_pin_oe;
    logic [`SLP_PC_W-1:0] pc, prefetch;
    logic [`SLP_IO_W-1:0] io_in, oe_in, io_q, oe_q;
    int n_mismatch = 0;
    int total_checks = 0;
    int n, m;

    always #4 clk = ~clk;

    slp_core_model core (.i_core_clk(clk), .o_sleep_exec(sleep_x),
        .o_clrwdt_exec(clrwdt), .o_pc(pc), .o_ext_pin(ext_pin),
        .o_port_change(port_c), .o_cmp_change(cmp_c), .o_io_out(io_in),
        .o_io_oe(oe_in));

    slp_ctrl #(.P_WDT_TIMEOUT_CYCLES(50)) uut (.i_core_clk(clk), .i_rst(rst),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_sleep_exec(sleep_x),
        .i_clrwdt_exec(clrwdt), .i_pc(pc), .o_prefetch_addr(prefetch),
        .o_core_clk_en(clk_en), .o_osc_drv_en(osc_en), .o_resume(resume),
        .o_vector_req(vec), .i_master_clear_pin_n(master_clear_pin_n),
        .o_master_clear_pin_oe(master_clear_pin_oe), .o_dev_reset(dev_rst),
        .o_wdt_reset(wdt_rst), .i_external_edge_irq_pin(ext_pin),
        .i_port_change(port_c), .i_cmp_change(cmp_c), .i_io_out(io_in),
        .i_io_oe(oe_in), .o_io_out(io_q), .o_io_oe(oe_q),
        .o_timeout_flag(to_f), .o_power_down_flag(pd_f), .o_irq(irq));

    task end_of_test;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        @(posedge clk);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge clk);
            k++;
        end
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            n_mismatch++;
            end_of_test();
        end
    endtask : apb

    task wait_res(input int lim);
        n = 0;
        while (resume !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (n >= lim) begin
            n_mismatch++;
            end_of_test();
        end
    endtask : wait_res

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("power down", 1, pd_f);
        apb(0, 8'h00, 0);
        chk("ctrl", 32'h81, q);
        core.pins(1'b1, 13'h0A5A, 13'h1FFF);
        apb(0, 8'h08, 0);
        chk("ext flag", 32'h1, q);
        apb(1, 8'h08, 32'h1);
        apb(1, 8'h00, 32'h26);
        apb(0, 8'h04, 0);
        chk("status", 32'h3, q);
        apb(0, 8'h18, 0);
        chk("slverr", 1, perr);
        apb(1, 8'h10, 32'h7);
        core.sleep_at(11'h123);
        @(posedge clk);
        chk("prefetch", 11'h124, prefetch);
        chk("gates", 2'b00, {clk_en, osc_en});
        chk("flags", 2'b01, {pd_f, to_f});
        core.pins(1'b1, 13'h15A5, 13'h00F0);
        repeat (2) @(posedge clk);
        chk("io hold", 13'h0A5A, io_q);
        chk("oe hold", 13'h1FFF, oe_q);
        apb(0, 8'h04, 0);
        chk("status asleep", 32'h5, q);
        chk("irq", 1, irq);
        apb(1, 8'h0C, 32'h7);
        repeat (2) @(posedge clk);
        chk("irq clear", 0, irq);
        core.pulse(1'b1);
        repeat (3) @(posedge clk);
        apb(0, 8'h08, 0);
        chk("src flags", 32'h4, q);
        chk("still asleep", 0, clk_en);
        apb(1, 8'h08, 32'h4);
        core.pulse(1'b0);
        wait_res(20);
        chk("vector off", 0, vec);
        for (m = 0; m < 4; m++) begin
            apb(1, 8'h08, 32'h7);
            apb(1, 8'h0C, 32'h7);
            apb(1, 8'h00, 32'h20 | (m << 1) | ((m & 1) << 3));
            core.pulse(1'b0);
            repeat (2) @(posedge clk);
            core.sleep_at(11'h040);
            wait_res(1100);
            chk("wake delay", 1, (m == 3) ? n < 10 : n >= 1024 && n < 1040);
            chk("vector", m & 1, vec);
        end
        apb(1, 8'h00, 32'h07);
        core.sleep_at(11'h200);
        wait_res(200);
        chk("timeout flag", 0, to_f);
        apb(0, 8'h14, 0);
        chk("wdt cleared", 1, q < 20);
        n = 0;
        while (wdt_rst !== 1'b1 && n < 80) begin
            @(posedge clk);
            n++;
        end
        chk("wdt reset", 1, n < 80);
        chk("pin drive", 0, master_clear_pin_oe);
        core.clear_watchdog();
        @(posedge clk);
        chk("clear flags", 2'b11, {pd_f, to_f});
        apb(1, 8'h00, 32'h06);
        core.sleep_at(11'h300);
        master_clear_pin_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk("device reset", 1, dev_rst);
        master_clear_pin_n <= 1'b1;
        m = 0;
        repeat (20) begin
            @(posedge clk);
            m = m | resume;
        end
        chk("no resume", 0, m);
        end_of_test();
    end
endmodule : sleep_wakeup_control_tb_top
